/* File: src/pec_defines.svh */
// Purpose: Named constants for the enable and power-block control logic
// Assumes: Register index times four is the byte address on APB
// Notes:   Eight data bits per register, upper bits read as zero
`ifndef PEC_DEFINES_SVH
`define PEC_DEFINES_SVH

// ==================================================================
// Register indices
`define PEC_IDX_ENA    3'h1
`define PEC_IDX_BUCK   3'h2
`define PEC_IDX_LATCH  3'h3
`define PEC_IDX_BGAP   3'h4
`define PEC_IDX_MAXSW  3'h6
`define PEC_IDX_STAT   3'h7

// ==================================================================
// Field positions
`define PEC_ENA_CONV   0
`define PEC_ENA_LDO    1
`define PEC_ENA_TINY   2
`define PEC_ENA_BUCK   3
`define PEC_ENA_SECOND_AUXILIARY_SWITCH_OUTPUT   4
`define PEC_ENA_SW     5
`define PEC_ENA_IRQ    6
`define PEC_BUCK_MLO   4
`define PEC_BUCK_MHI   5
`define PEC_LATCH_BIT  7
`define PEC_BGAP_EARLY 5
`define PEC_MAXSW_DIS  6
`define PEC_MAXSW_EN   7

// ==================================================================
// Writable masks and factory defaults
`define PEC_ENA_MASK   8'h7f
`define PEC_BUCK_MASK  8'h30
`define PEC_LATCH_MASK 8'h80
`define PEC_BGAP_MASK  8'h20
`define PEC_MAXSW_MASK 8'hc0
`define PEC_ENA_RST    8'h00
`define PEC_BUCK_RST   8'h00
`define PEC_LATCH_RST  8'h00
`define PEC_BGAP_RST   8'h00
`define PEC_MAXSW_RST  8'h00

`endif

/* File: src/pec_pkg.sv */
// Purpose: Types shared by the enable and power-block control logic
// Assumes: Nothing beyond the defines header
// Notes:   Mode codes follow the register field encodings
package pec_pkg;

  // ================================================================
  // Always-on supply option, fixed at the factory
  typedef enum logic [1:0] {
    PEC_AON_ZERO_BIAS = 2'h0,
    PEC_AON_TINY_LDO  = 2'h1,
    PEC_AON_SMALL_BUCK = 2'h2
  } pec_aon_t;

  // ================================================================
  // Small buck power mode field
  typedef enum logic [1:0] {
    PEC_BUCK_AUTO  = 2'h0,
    PEC_BUCK_AUTO1 = 2'h1,
    PEC_BUCK_LOW   = 2'h2,
    PEC_BUCK_HIGH  = 2'h3
  } pec_buck_mode_t;

  // ================================================================
  // Maximum-supply switch options, {enable bit, disable bit}
  typedef enum logic [1:0] {
    PEC_MAX_DIODE    = 2'h0,
    PEC_MAX_BATTERY  = 2'h1,
    PEC_MAX_FOLLOW   = 2'h2,
    PEC_MAX_FALLBACK = 2'h3
  } pec_max_mode_t;

  // ================================================================
  // Block enables driven to the analog side
  typedef struct packed {
    logic           micro_bias_rail;
    logic           pulldowns;
    logic           serial_if;
    logic           converter;
    logic           main_ldo;
    logic           tiny_linear_regulator;
    logic           small_hysteretic_buck;
    logic           bandgap;
    logic           second_auxiliary_switch_output;
    logic           power_switches;
    logic           irq_logic;
    logic           deep_sleep;
    pec_buck_mode_t buck_mode;
    pec_max_mode_t  max_supply_rail;
    logic           max_latch;
  } pec_blocks_t;

endpackage

/* File: src/pec_enable_control.sv */
// Purpose: Enable pins plus register bits decide which power blocks run
// Assumes: presetn is the power-on reset; pins are asynchronous to pclk
// Notes:   Registers reached over APB, one wait state on every access
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/1ns
`include "pec_defines.svh"

module pec_enable_control
  import pec_pkg::*;
#(
  parameter int       ADDR_W  = 12,
  parameter pec_aon_t AON_SEL = PEC_AON_TINY_LDO
)
(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                clk_en,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                chip_enable_pin,
  input  wire logic                converter_enable_pin,
  output pec_blocks_t              blocks
);

  // ================================================================
  // Elaboration checks
  generate
    if (ADDR_W < 5)
    begin : g_addr_chk
      $error("ADDR_W too narrow for the register map");
    end
    if (ADDR_W > 32)
    begin : g_addr_max
      $error("ADDR_W wider than an APB address");
    end
    if (AON_SEL == 2'h3)
    begin : g_aon_chk
      $error("AON_SEL holds an undefined option");
    end
  endgenerate

  // ================================================================
  // Pin synchronisers
  logic [1:0] ce_sync_q;
  logic [1:0] ce_sync_d;
  logic [1:0] cv_sync_q;
  logic [1:0] cv_sync_d;
  logic       ce_s;
  logic       cv_s;

  // Only the second stage feeds logic; costs two cycles of pin latency

  always_comb
  begin
    ce_sync_d = {ce_sync_q[0], chip_enable_pin};
    cv_sync_d = {cv_sync_q[0], converter_enable_pin};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ce_sync_q <= 2'h0;
      cv_sync_q <= 2'h0;
    end
    else if (clk_en)
    begin
      ce_sync_q <= ce_sync_d;
      cv_sync_q <= cv_sync_d;
    end
  end

  assign ce_s = ce_sync_q[1];
  assign cv_s = cv_sync_q[1];

  // ================================================================
  // APB slave and register file
  logic [7:0]  ena_q;
  logic [7:0]  ena_d;
  logic [7:0]  buck_q;
  logic [7:0]  buck_d;
  logic [7:0]  latch_q;
  logic [7:0]  latch_d;
  logic [7:0]  bgap_q;
  logic [7:0]  bgap_d;
  logic [7:0]  maxsw_q;
  logic [7:0]  maxsw_d;
  logic        pready_q;
  logic        pready_d;
  logic        pslverr_q;
  logic        pslverr_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic        acc;
  logic        wr_fire;
  logic        mapped;
  logic        upper_zero;
  logic [2:0]  idx;
  logic [7:0]  wbyte;
  logic [7:0]  rbyte;
  logic [7:0]  status;

  // Word aligned: register index sits in address bits 4:2
  assign idx        = paddr[4:2];
  assign upper_zero = (paddr[ADDR_W-1:5] == '0) && (paddr[1:0] == 2'h0);
  // One wait state: pready rises the cycle after the access phase opens
  // A write lands on the very edge that raises pready
  assign acc        = psel && penable && !pready_q;
  assign wbyte      = pwdata[7:0];

  always_comb
  begin
    unique case (idx)
      `PEC_IDX_ENA,
      `PEC_IDX_BUCK,
      `PEC_IDX_LATCH,
      `PEC_IDX_BGAP,
      `PEC_IDX_MAXSW,
      `PEC_IDX_STAT: mapped = upper_zero;
      default:       mapped = 1'b0;
    endcase
  end

  // Writes refused while the serial port sleeps; reads still allowed
  assign wr_fire = acc && pwrite && mapped && ce_s && pstrb[0];

  always_comb
  begin
    unique case (idx)
      `PEC_IDX_ENA:   rbyte = ena_q;
      `PEC_IDX_BUCK:  rbyte = buck_q;
      `PEC_IDX_LATCH: rbyte = latch_q;
      `PEC_IDX_BGAP:  rbyte = bgap_q;
      `PEC_IDX_MAXSW: rbyte = maxsw_q;
      `PEC_IDX_STAT:  rbyte = status;
      default:        rbyte = 8'h00;
    endcase
  end

  always_comb
  begin
    pready_d  = acc;
    pslverr_d = 1'b0;
    // Unmapped words and write cycles read back zero
    prdata_d  = 32'h0;
    if (acc)
    begin
      // Refused access still completes, flagged rather than stalled
      pslverr_d = !mapped || (pwrite && !ce_s);
      if (!pwrite && mapped)
      begin
        prdata_d = {24'h0, rbyte};
      end
    end
  end

  // Registers change only on a write; chip enable dropping keeps them
  always_comb
  begin
    // Reserved bits masked below so they read back as zero
    ena_d   = ena_q;
    buck_d  = buck_q;
    latch_d = latch_q;
    bgap_d  = bgap_q;
    maxsw_d = maxsw_q;
    if (wr_fire)
    begin
      unique case (idx)
        `PEC_IDX_ENA:   ena_d   = wbyte & `PEC_ENA_MASK;
        `PEC_IDX_BUCK:  buck_d  = wbyte & `PEC_BUCK_MASK;
        `PEC_IDX_LATCH: latch_d = wbyte & `PEC_LATCH_MASK;
        `PEC_IDX_BGAP:  bgap_d  = wbyte & `PEC_BGAP_MASK;
        `PEC_IDX_MAXSW: maxsw_d = wbyte & `PEC_MAXSW_MASK;
        default:        ena_d   = ena_q;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ena_q     <= `PEC_ENA_RST;
      buck_q    <= `PEC_BUCK_RST;
      latch_q   <= `PEC_LATCH_RST;
      bgap_q    <= `PEC_BGAP_RST;
      maxsw_q   <= `PEC_MAXSW_RST;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end
    else if (clk_en)
    begin
      ena_q     <= ena_d;
      buck_q    <= buck_d;
      latch_q   <= latch_d;
      bgap_q    <= bgap_d;
      maxsw_q   <= maxsw_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q  <= prdata_d;
    end
  end

  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign prdata  = prdata_q;

  // ================================================================
  // Block enable decisions
  // Every enable leaves through one flop so that a pin edge
  // and a register write never glitch an enable together
  pec_blocks_t blk_q;
  pec_blocks_t blk_d;
  logic        tiny_on;
  logic        buck_on;
  logic        ldo_on;

  // An always-on supply runs regardless of chip enable
  always_comb
  begin
    ldo_on  = ce_s && ena_q[`PEC_ENA_LDO];
    tiny_on = (AON_SEL == PEC_AON_TINY_LDO)
           || (ce_s && ena_q[`PEC_ENA_TINY]);
    buck_on = (AON_SEL == PEC_AON_SMALL_BUCK)
           || (ce_s && ena_q[`PEC_ENA_BUCK]);
  end

  always_comb
  begin
    blk_d.micro_bias_rail  = 1'b1;
    blk_d.pulldowns        = !ce_s;
    blk_d.serial_if        = ce_s;
    blk_d.deep_sleep       = !ce_s && !cv_s;
    // Pin alone enables the converter without serial access
    blk_d.converter        = cv_s
                          || (ce_s && ena_q[`PEC_ENA_CONV]);
    blk_d.main_ldo         = ldo_on;
    blk_d.tiny_linear_regulator = tiny_on;
    blk_d.small_hysteretic_buck = buck_on;
    blk_d.bandgap          = ldo_on || tiny_on || buck_on
                          || (ce_s && bgap_q[`PEC_BGAP_EARLY]);
    // Pin becomes the inductor node of the buck
    blk_d.second_auxiliary_switch_output = ce_s && ena_q[`PEC_ENA_SECOND_AUXILIARY_SWITCH_OUTPUT]
                                        && !buck_on;
    blk_d.power_switches   = ce_s && ena_q[`PEC_ENA_SW];
    blk_d.irq_logic        = ce_s && ena_q[`PEC_ENA_IRQ];
    blk_d.buck_mode        = pec_buck_mode_t'(buck_q[`PEC_BUCK_MHI:`PEC_BUCK_MLO]);
    // Enable bit is the high bit of the option code
    blk_d.max_supply_rail  = pec_max_mode_t'({maxsw_q[`PEC_MAXSW_EN],
                                              maxsw_q[`PEC_MAXSW_DIS]});
    blk_d.max_latch        = latch_q[`PEC_LATCH_BIT];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // Reset state is deep sleep with bias rail and pull-downs on
      blk_q                  <= '0;
      blk_q.micro_bias_rail  <= 1'b1;
      blk_q.pulldowns        <= 1'b1;
      blk_q.deep_sleep       <= 1'b1;
    end
    else if (clk_en)
    begin
      blk_q <= blk_d;
    end
  end

  assign blocks = blk_q;

  // Live view of pins and block state for software
  // Pins shown as synchronised, one edge ahead of blocks
  assign status = {blk_q.deep_sleep, blk_q.bandgap, blk_q.converter,
                   blk_q.small_hysteretic_buck, blk_q.tiny_linear_regulator,
                   blk_q.main_ldo, cv_s, ce_s};

endmodule // pec_enable_control

/* File: dv/pec_enable_control_asserts.sv */
// Purpose: Port checks of the enable control block
// Assumes: clk_en held high by the bench
// Notes:   Pin effects land three edges after a pin moves
`timescale 1ns/1ns
module pec_enable_control_asserts
  import pec_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              clk_en,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              chip_enable_pin,
  input wire logic              converter_enable_pin,
  input wire pec_blocks_t       blocks
);
  // ==============================================================
  // Helpers
  logic [1:0] up_q;
  logic [1:0] up_d;
  logic       acc;
  logic       live;
  // Pin history is only trusted once three edges follow reset
  always_comb up_d = (up_q == 2'h3) ? up_q : up_q + 2'h1;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      up_q <= 2'h0;
    else
      up_q <= up_d;
  assign acc  = psel && penable && !pready;
  assign live = (up_q == 2'h3);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !clk_en);

  // ==============================================================
  // Assertions
  a_bias_always: assert property (blocks.micro_bias_rail)
    else $error("micro bias rail dropped");
  a_deep_sleep_pins: assert property (live |-> blocks.deep_sleep ==
    (!$past(chip_enable_pin, 3) && !$past(converter_enable_pin, 3)))
    else $error("deep sleep does not follow pins");
  a_serial_follows: assert property (live |-> blocks.serial_if ==
    $past(chip_enable_pin, 3) && blocks.pulldowns == !$past(chip_enable_pin, 3))
    else $error("serial or pulldowns wrong");
  a_conv_pin: assert property (live && $past(converter_enable_pin, 3) |-> blocks.converter)
    else $error("converter pin ignored");
  a_off_when_off: assert property (!blocks.serial_if |->
    !(blocks.power_switches || blocks.irq_logic || blocks.main_ldo))
    else $error("block on while chip disabled");
  a_bandgap_auto: assert property ((blocks.main_ldo || blocks.tiny_linear_regulator ||
    blocks.small_hysteretic_buck) |-> blocks.bandgap)
    else $error("bandgap off under regulator");
  a_second_auxiliary_switch_output_blocked: assert property (blocks.small_hysteretic_buck |->
    !blocks.second_auxiliary_switch_output)
    else $error("second_auxiliary_switch_output on with small buck");
  a_ready_one_wait: assert property (acc |=> pready ##1 !pready)
    else $error("pready timing wrong");
  a_bad_index_err: assert property (acc && paddr[4:2] == 3'h5 |=> pslverr)
    else $error("unmapped index accepted");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_mode_by_write: assert property ($changed(blocks.buck_mode) ||
    $changed(blocks.max_supply_rail) |-> $past(pready && pwrite))
    else $error("mode changed without write");
  c_wake: cover property ($fell(blocks.deep_sleep));
  c_err: cover property (pslverr);
  c_buck_high: cover property (blocks.buck_mode == PEC_BUCK_HIGH);
endmodule // pec_enable_control_asserts

bind pec_enable_control pec_enable_control_asserts #(.ADDR_W(ADDR_W)) u_chk (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .chip_enable_pin(chip_enable_pin), .converter_enable_pin(converter_enable_pin),
  .blocks(blocks));

/* File: dv/pec_host_model.sv */
// Purpose: Host side, enable pins and APB master
// Assumes: Tasks called one at a time
// Notes:   Released bus lines show inverted data
`timescale 1ns/1ns
module pec_host_model
(
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb,
  output logic             chip_enable_pin,
  output logic             converter_enable_pin
);
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'h1;
    {chip_enable_pin, converter_enable_pin} = 2'h0;
  end

  // ==============================================================
  // Tasks
  task automatic pins(input logic ce, input logic cv);
    @(posedge pclk);
    chip_enable_pin      <= ce;
    converter_enable_pin <= cv;
  endtask

  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
                      output logic [7:0] rd, output logic er);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    // Answer taken at the rising edge that samples pready high
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata[7:0];
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~{24'h0, d};
  endtask
endmodule // pec_host_model

/* File: dv/tb_pmic_enable_control.sv */
// Purpose: Self-checking bench of the enable control block
// Assumes: Zero-bias always-on option, so bandgap follows regulators and the early bandgap bit only
// Notes:   Row table first, awkward cases after it
`timescale 1ns/1ns
`include "pec_defines.svh"
module tb_pmic_enable_control import pec_pkg::*;;
  typedef struct packed {
    logic       ce;
    logic       cv;
    logic [7:0] ena;
    logic [5:0] exp;
  } pec_row_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        chip_enable_pin, converter_enable_pin;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  pec_blocks_t blocks;
  int          failures, compares;
  // Exp: deep_sleep serial_if converter main_ldo bandgap power_switches; ena 80 = no write
  pec_row_t rows [8] = '{'{1'b0, 1'b0, 8'h80, 6'h20}, '{1'b0, 1'b1, 8'h80, 6'h08},
    '{1'b1, 1'b0, 8'h01, 6'h18}, '{1'b1, 1'b0, 8'h22, 6'h17}, '{1'b1, 1'b1, 8'h00, 6'h18},
    '{1'b1, 1'b0, 8'h04, 6'h12}, '{1'b0, 1'b0, 8'h80, 6'h20}, '{1'b1, 1'b0, 8'h80, 6'h12}};
  logic [2:0] idxs [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h6};

  pec_enable_control #(.ADDR_W(12), .AON_SEL(PEC_AON_ZERO_BIAS)) u_dut (
    .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .chip_enable_pin(chip_enable_pin),
    .converter_enable_pin(converter_enable_pin), .blocks(blocks));
  pec_host_model u_host (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .chip_enable_pin(chip_enable_pin),
    .converter_enable_pin(converter_enable_pin));

  always #10 pclk = ~pclk;

  // ==============================================================
  // Tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic acc(input logic w, input logic [2:0] i, input logic [7:0] d, input logic ee);
    logic [7:0] r;
    logic       e;
    u_host.xfer(w, {7'h0, i, 2'h0}, d, r, e);
    chk({7'h0, e}, {7'h0, ee});
    if (!w)
      chk(r, d);
  endtask

  task automatic settle();
    repeat (4) @(posedge pclk);
    @(negedge pclk);
  endtask

  task automatic end_of_test();
    $display("counts: compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge pclk);
    failures++;
    end_of_test();
  end

  // ==============================================================
  // Main sequence
  initial
  begin
    pclk     = 1'b0;
    presetn  = 1'b0;
    failures = 0;
    compares = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i])
    begin
      u_host.pins(rows[i].ce, rows[i].cv);
      if (rows[i].ena[7] == 1'b0)
        acc(1'b1, `PEC_IDX_ENA, rows[i].ena, 1'b0);
      settle();
      chk({2'h0, blocks.deep_sleep, blocks.serial_if, blocks.converter, blocks.main_ldo,
           blocks.bandgap, blocks.power_switches}, {2'h0, rows[i].exp});
    end
    $display("test rows done");
    acc(1'b1, `PEC_IDX_BUCK, 8'h30, 1'b0);
    acc(1'b0, `PEC_IDX_BUCK, 8'h30, 1'b0);
    settle();
    chk({6'h0, blocks.buck_mode}, {6'h0, PEC_BUCK_HIGH});
    acc(1'b1, `PEC_IDX_BUCK, 8'h20, 1'b0);
    acc(1'b1, `PEC_IDX_ENA, 8'h18, 1'b0);
    settle();
    chk({6'h0, blocks.buck_mode}, {6'h0, PEC_BUCK_LOW});
    chk({6'h0, blocks.small_hysteretic_buck, blocks.second_auxiliary_switch_output}, 8'h02);
    acc(1'b1, `PEC_IDX_ENA, 8'h00, 1'b0);
    settle();
    chk({7'h0, blocks.bandgap}, 8'h00);
    acc(1'b1, `PEC_IDX_BGAP, 8'h20, 1'b0);
    settle();
    chk({7'h0, blocks.bandgap}, 8'h01);
    for (int m = 0; m < 4; m++)
    begin
      acc(1'b1, `PEC_IDX_MAXSW, {m[1:0], 6'h00}, 1'b0);
      settle();
      chk({6'h0, blocks.max_supply_rail}, {6'h0, m[1:0]});
    end
    $display("test modes done");
    acc(1'b1, 3'h5, 8'h01, 1'b1);
    acc(1'b0, 3'h5, 8'h00, 1'b1);
    acc(1'b1, `PEC_IDX_ENA, 8'h20, 1'b0);
    u_host.pins(1'b0, 1'b0);
    settle();
    chk({7'h0, blocks.power_switches}, 8'h00);
    acc(1'b1, `PEC_IDX_ENA, 8'h01, 1'b1);
    acc(1'b0, `PEC_IDX_ENA, 8'h20, 1'b0);
    u_host.pins(1'b1, 1'b0);
    settle();
    chk({7'h0, blocks.power_switches}, 8'h01);
    acc(1'b1, `PEC_IDX_ENA, 8'h44, 1'b0);
    acc(1'b1, `PEC_IDX_LATCH, 8'h80, 1'b0);
    settle();
    chk({5'h0, blocks.tiny_linear_regulator, blocks.irq_logic, blocks.max_latch}, 8'h07);
    acc(1'b0, `PEC_IDX_STAT, 8'h49, 1'b0);
    $display("test refusals done");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    for (int k = 0; k < 5; k++)
      acc(1'b0, idxs[k], 8'h00, 1'b0);
    chk({6'h0, blocks.buck_mode}, {6'h0, PEC_BUCK_AUTO});
    $display("test reset done");
    end_of_test();
  end
endmodule // tb_pmic_enable_control
